// >>> src/startup_link_cal_sequence.sv
// Link and calibration state machines with startup sequencing controls
// Operation
// - Link enable low halts link machine
// - Calibration enable low halts calibration machine
// - Multiframe field holds frames minus one
// - Sync source picks single-ended or timestamp
// - Foreground/background and independent offset calibration
// - Calibration enable high starts calibration machine
// - Overrange detect enable with adjustable settings
// - Link enable high restarts with new settings
// - Link transmitter follows receiver sync request
// - Trigger rising edge starts a calibration
`default_nettype none
module startup_link_cal_sequence
  import startup_seq_pkg::*;
#(
  parameter logic [15:0] CAL_LEN = CAL_RUN_LEN  // Foreground calibration length in cycles
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Link configuration
  input  wire logic              serial_link_enable,
  input  wire logic [MODE_W-1:0] link_mode_select,
  input  wire logic [KM1_W-1:0]  multiframe_length_minus_one,
  input  wire logic              sync_source_select,  // 0 single-ended, 1 timestamp pair
  // Sync inputs from the receiver (pins)
  input  wire logic              single_ended_sync_input,
  input  wire logic              timestamp_sync_input,
  // Calibration configuration
  input  wire logic              calibration_enable,
  input  wire logic              background_mode,     // 0 foreground, 1 background
  input  wire logic              offset_cal_enable,
  input  wire logic              calibration_software_trigger,
  // Overrange
  input  wire logic              overrange_detect_enable,
  input  wire logic [OVR_W-1:0]  overrange_threshold,
  input  wire logic [OVR_W-1:0]  sample_magnitude,
  // Status
  output logic                   link_running,
  output logic                   link_in_cgs,         // Sending code groups
  output logic                   link_data_phase,     // Sending ILA or user data
  output logic [KM1_W:0]         frames_per_multiframe,
  output logic [MODE_W-1:0]      active_link_mode,
  output logic                   cal_running,
  output logic                   cal_busy,
  output logic                   cal_offset_active,
  output logic                   cal_done,
  output logic                   overrange_flag
);

  typedef enum logic [1:0] {LINK_OFF, LINK_CGS, LINK_ILA, LINK_DATA} link_state_t;
  typedef enum logic [1:0] {CAL_OFF, CAL_IDLE, CAL_RUN, CAL_BG} cal_state_t;

  link_state_t       link_q;      // Link machine state
  cal_state_t        cal_q;       // Calibration machine state
  logic [1:0]        sync_se_q;   // Single-ended sync synchroniser
  logic [1:0]        sync_ts_q;   // Timestamp sync synchroniser
  logic [1:0]        trig_q;      // Trigger synchroniser
  logic              trig_last_q; // Previous synchronised trigger
  logic [KM1_W-1:0]  km1_q;       // Multiframe count latched at link start
  logic [KM1_W-1:0]  frame_cnt_q; // Frame position within multiframe
  logic              bg_q;        // Calibration mode latched at start
  logic              ofs_q;       // Offset enable latched at start
  logic [CAL_CYCLES_W-1:0] cal_cnt_q; // Run counter for the foreground run and the first background pass
  logic              sync_req;    // Selected sync request, active low on the link
  logic              trig_rise;   // Trigger 0-to-1 edge

  // Pins cross two flops before anything reads them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_se_q <= 2'h3;
      sync_ts_q <= 2'h3;
      trig_q    <= 2'h0;
    end else begin
      sync_se_q <= {sync_se_q[0], single_ended_sync_input};
      sync_ts_q <= {sync_ts_q[0], timestamp_sync_input};
      trig_q    <= {trig_q[0], calibration_software_trigger};
    end
  end

  // Sync source mux after the synchronisers
  assign sync_req = sync_source_select ? sync_ts_q[1] : sync_se_q[1];

  // Link machine; mode and multiframe length are only sampled on restart
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_q           <= LINK_OFF;
      km1_q            <= KM1_RESET;
      active_link_mode <= MODE_RESET;
      frame_cnt_q      <= '0;
    end else if (!serial_link_enable) begin
      link_q <= LINK_OFF;
    end else begin
      case (link_q)
        LINK_OFF: begin
          // Restart with new mode and multiframe length
          link_q           <= LINK_CGS;
          km1_q            <= multiframe_length_minus_one;
          active_link_mode <= link_mode_select;
          frame_cnt_q      <= '0;
        end
        LINK_CGS: begin
          // Sync released by receiver: begin alignment sequence
          if (sync_req) begin
            link_q      <= LINK_ILA;
            frame_cnt_q <= '0;
          end
        end
        LINK_ILA, LINK_DATA: begin
          if (!sync_req) begin
            link_q <= LINK_CGS;
          end else begin
            // Wrap at stored value, giving K frames per multiframe
            if (frame_cnt_q == km1_q) begin
              frame_cnt_q <= '0;
              link_q      <= LINK_DATA;
            end else begin
              frame_cnt_q <= frame_cnt_q + 1'b1;
            end
          end
        end
        default: link_q <= LINK_OFF;
      endcase
    end
  end

  assign trig_rise = trig_q[1] & ~trig_last_q;

  // Trigger edge history
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trig_last_q <= 1'b0;
    end else begin
      trig_last_q <= trig_q[1];
    end
  end

  // Calibration machine; options latched when enable takes the machine out of CAL_OFF
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cal_q     <= CAL_OFF;
      bg_q      <= 1'b0;
      ofs_q     <= 1'b0;
      cal_cnt_q <= '0;
      cal_done  <= 1'b0;
    end else if (!calibration_enable) begin
      cal_q    <= CAL_OFF;
      cal_done <= 1'b0;
    end else begin
      case (cal_q)
        CAL_OFF: begin
          // Enable takes the settings programmed while stopped
          cal_q <= CAL_IDLE;
          bg_q  <= background_mode;
          ofs_q <= offset_cal_enable;
        end
        CAL_IDLE: begin
          if (trig_rise) begin
            // Background runs on; foreground counts out a fixed run
            cal_q     <= bg_q ? CAL_BG : CAL_RUN;
            cal_cnt_q <= CAL_LEN;
            cal_done  <= 1'b0;
          end
        end
        CAL_RUN: begin
          if (cal_cnt_q <= 16'h0001) begin
            cal_q    <= CAL_IDLE;
            cal_done <= 1'b1;
          end else begin
            cal_cnt_q <= cal_cnt_q - 1'b1;
          end
        end
        CAL_BG: begin
          // Runs until enable drops; done marks first pass
          if (cal_cnt_q <= 16'h0001) begin
            cal_done <= 1'b1;
          end else begin
            cal_cnt_q <= cal_cnt_q - 1'b1;
          end
        end
        default: cal_q <= CAL_OFF;
      endcase
    end
  end

  // Registered status outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_running          <= 1'b0;
      link_in_cgs           <= 1'b0;
      link_data_phase       <= 1'b0;
      frames_per_multiframe <= '0;
      cal_running           <= 1'b0;
      cal_busy              <= 1'b0;
      cal_offset_active     <= 1'b0;
    end else begin
      link_running          <= (link_q != LINK_OFF);
      link_in_cgs           <= (link_q == LINK_CGS);
      link_data_phase       <= (link_q == LINK_ILA) || (link_q == LINK_DATA);
      frames_per_multiframe <= {1'b0, km1_q} + 1'b1;
      cal_running           <= (cal_q != CAL_OFF);
      cal_busy              <= (cal_q == CAL_RUN) || (cal_q == CAL_BG);
      cal_offset_active     <= ofs_q && ((cal_q == CAL_RUN) || (cal_q == CAL_BG));
    end
  end

  // Overrange detection, live settings since it is not gated by a machine
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overrange_flag <= 1'b0;
    end else begin
      overrange_flag <= overrange_detect_enable &&
                        (sample_magnitude >= overrange_threshold);
    end
  end

endmodule
`default_nettype wire

// >>> src/startup_seq_pkg.sv
// Constants shared by the startup, link and calibration sequencing block
package startup_seq_pkg;
  localparam int          MODE_W        = 5;   // Link mode select width
  localparam int          KM1_W         = 5;   // Multiframe length minus one width
  localparam int          OVR_W         = 8;   // Overrange threshold width
  localparam int          CAL_CYCLES_W  = 16;  // Calibration run counter width
  localparam logic [15:0] CAL_RUN_LEN   = 16'h0400; // Default foreground run length
  localparam logic [4:0]  MODE_RESET    = 5'h00;
  localparam logic [4:0]  KM1_RESET     = 5'h1f;
  localparam logic [7:0]  OVR_RESET     = 8'hf0;
endpackage

// >>> test/seq_checker.sv
// Port assertions for the startup sequencer
`default_nettype none
module seq_checker
  import startup_seq_pkg::*;
(
  // Clock, reset and controls
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic             serial_link_enable,
  input wire logic             calibration_enable,
  input wire logic             calibration_software_trigger,
  input wire logic [KM1_W-1:0] multiframe_length_minus_one,
  // Status
  input wire logic             link_running,
  input wire logic [KM1_W:0]   frames_per_multiframe,
  input wire logic             cal_running,
  input wire logic             cal_busy
);
  timeunit 1ns / 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire cal_idle = cal_running && !cal_busy;  // Only an idle machine may take a trigger
  a_link_halt: assert property (link_running |-> $past(serial_link_enable, 2))
    else $error("link runs after enable low");
  a_link_start: assert property ($rose(serial_link_enable) |-> ##[1:3] link_running)
    else $error("link did not restart");
  a_cal_halt: assert property (cal_running |-> $past(calibration_enable, 2))
    else $error("calibration runs after enable low");
  a_busy_halt: assert property (!calibration_enable [*3] |-> !cal_busy)
    else $error("busy after enable low");
  a_cal_start: assert property ($rose(calibration_enable) |-> ##[1:3] cal_running)
    else $error("calibration did not start");
  a_mf_latch: assert property ($rose(link_running) |->
    frames_per_multiframe == multiframe_length_minus_one + 1'b1) else $error("bad frame count");
  a_trig_run: assert property ($rose(calibration_software_trigger) && cal_idle
    |-> ##[2:7] cal_busy) else $error("trigger edge ignored");
  a_busy_idle: assert property ($rose(cal_busy) |-> $past(cal_idle))
    else $error("run began outside idle");
  c_link: cover property ($rose(link_running));
  c_busy: cover property ($rose(cal_busy));
  c_end: cover property ($fell(cal_busy));
endmodule
bind startup_link_cal_sequence seq_checker chk (.*);
`default_nettype wire

// >>> test/startup_link_cal_sequence_tb_top.sv
// Self-checking bench for the startup sequencer
`default_nettype none
module startup_link_cal_sequence_tb_top;
  timeunit 1ns / 1ns;
  import startup_seq_pkg::*;
  logic              clock, rst_n, serial_link_enable, sync_source_select, release_ok;
  logic [MODE_W-1:0] link_mode_select, active_link_mode;
  logic [KM1_W-1:0]  multiframe_length_minus_one;
  logic [KM1_W:0]    frames_per_multiframe;
  logic [OVR_W-1:0]  overrange_threshold, sample_magnitude;
  logic              calibration_enable, background_mode, offset_cal_enable, cal_busy;
  logic              calibration_software_trigger, overrange_detect_enable, link_running;
  logic              single_ended_sync_input, timestamp_sync_input, overrange_flag;
  logic              link_in_cgs, link_data_phase, cal_running, cal_offset_active, cal_done;
  int                err_total = 0, check_count = 0, cycles = 0;
  startup_link_cal_sequence #(.CAL_LEN(16'h0010)) DUT (.*);
  sync_receiver_model rx (.clock, .rst_n, .sel(sync_source_select), .link_in_cgs, .release_ok,
    .se_sync(single_ended_sync_input), .ts_sync(timestamp_sync_input));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reprogram with link stopped, restart, then release sync
  task automatic t_link(input logic sel, input logic [4:0] mode, input logic [4:0] km1);
    {serial_link_enable, release_ok} = 2'b00;
    @(negedge clock);
    {sync_source_select, link_mode_select, multiframe_length_minus_one} = {sel, mode, km1};
    @(negedge clock);
    serial_link_enable = 1'b1;
    repeat (8) @(negedge clock);
    chk({link_running, link_in_cgs, link_data_phase}, 3'b110);
    chk({active_link_mode, 1'b0, frames_per_multiframe}, {mode, 2'b00, km1} + 12'h001);
    release_ok = 1'b1;
    repeat (60) if (!link_data_phase) @(negedge clock);
    chk({link_in_cgs, link_data_phase}, 2'b01);
    serial_link_enable = 1'b0;
    repeat (3) @(negedge clock);
    chk({link_running, link_data_phase}, 2'b00);
  endtask
  // Edge while stopped is ignored; a fresh 0-to-1 starts a run
  task automatic t_cal(input logic bg, input logic off);
    {calibration_enable, calibration_software_trigger} = 2'b01;
    @(negedge clock);
    {background_mode, offset_cal_enable} = {bg, off};
    @(negedge clock);
    calibration_enable = 1'b1;
    repeat (8) @(negedge clock);
    chk({cal_running, cal_busy}, 2'b10);
    calibration_software_trigger = 1'b0;
    repeat (3) @(negedge clock);
    calibration_software_trigger = 1'b1;
    repeat (10) if (!cal_busy) @(negedge clock);
    chk({cal_busy, cal_offset_active}, {1'b1, off});
    repeat (40) @(negedge clock);
    chk({cal_busy, cal_done}, {bg, 1'b1});
    calibration_enable = 1'b0;
    repeat (3) @(negedge clock);
    chk({cal_running, cal_busy, cal_done}, 3'b000);
  endtask
  initial begin
    rst_n = 1'b0;
    {serial_link_enable, sync_source_select, release_ok, link_mode_select} = '0;
    {multiframe_length_minus_one, calibration_enable, background_mode, offset_cal_enable} = '0;
    {calibration_software_trigger, overrange_detect_enable, overrange_threshold} = '0;
    sample_magnitude = 8'h00;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    t_link(1'b0, 5'h02, 5'h1f);
    t_link(1'b1, 5'h0b, 5'h00);
    t_cal(1'b0, 1'b1);
    t_cal(1'b1, 1'b0);
    {overrange_detect_enable, overrange_threshold, sample_magnitude} = {1'b1, 8'h05, 8'h05};
    repeat (2) @(negedge clock);
    chk(overrange_flag, 1'b1);
    sample_magnitude = 8'h04;
    repeat (2) @(negedge clock);
    chk(overrange_flag, 1'b0);
    {overrange_detect_enable, sample_magnitude} = {1'b0, 8'hff};
    repeat (2) @(negedge clock);
    chk(overrange_flag, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire

// >>> test/sync_receiver_model.sv
// Receiver model: sync request held low until the bench lets the link up
`default_nettype none
module sync_receiver_model #(
  parameter logic [3:0] DELAY = 4'h3  // Code-group cycles before release, 0 is prompt
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Bench control and link status
  input  wire logic sel,
  input  wire logic link_in_cgs,
  input  wire logic release_ok,
  // Sync pins, low asks for code groups
  output var  logic se_sync,
  output var  logic ts_sync
);
  timeunit 1ns / 1ns;
  logic [3:0] wait_q;  // Code-group cycles seen
  // Count code groups, release at DELAY
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
    end else if (!release_ok) begin
      wait_q <= 4'h0;
    end else if (link_in_cgs && wait_q != DELAY) begin
      wait_q <= wait_q + 4'h1;
    end
  end
  // Unused pin carries the inverse, so a wrong pick shows
  assign se_sync = (wait_q == DELAY) ^ sel;
  assign ts_sync = (wait_q == DELAY) ^ !sel;
endmodule
`default_nettype wire
